// ==== bench/ptc_pad_model.sv ====
`timescale 1ns/1ps
module ptc_pad_model (
    input  wire logic oe_i,      // Device drives pad
    input  wire logic d_i,       // Device drive value
    input  wire logic ext_en_i,  // Outside circuit drives pad
    input  wire logic ext_i,     // Outside drive value
    output logic      pad_o      // Resolved level, pull-up when nobody drives
);
    assign pad_o = oe_i ? d_i : (ext_en_i ? ext_i : 1'b1);
endmodule // ptc_pad_model

// ==== bench/ptc_pin_two_monitor.sv ====
`timescale 1ns/1ps
module ptc_pin_two_monitor #(
    parameter [4:0] CHIP_CODE = 5'h0_5,  // Arbitrary value
    parameter       ALT_RESET = 1'b0     // Factory alternate-function default
) (
    input wire logic       sys_clk_i,       // System clock
    input wire logic       rst_n_i,         // Async reset, active low
    input wire logic       reg_wr_i,        // Write strobe
    input wire logic       reg_rd_i,        // Read strobe
    input wire logic       pin_o,           // Pin drive value
    input wire logic       pin_oe_o,        // Pin output enable
    input wire logic       alt_lowpower_o,  // Alternate function active
    input wire logic [7:0] reg_addr_i,      // Register address
    input wire logic [7:0] reg_wdata_i,     // Write data
    input wire logic [7:0] reg_rdata_o      // Read data
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    wire ws = reg_wr_i && reg_addr_i == 8'h13;
    property p_code; reg_rd_i && reg_addr_i == 8'h14 |=> reg_rdata_o == {CHIP_CODE[4], 3'b000, CHIP_CODE[3:0]}; endproperty
    a_code: assert property (p_code) else $error("code read wrong");
    property p_hold; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_miss; reg_rd_i && reg_addr_i != 8'h13 && reg_addr_i != 8'h14 |=> reg_rdata_o == 8'h00; endproperty
    a_miss: assert property (p_miss) else $error("unmapped read not zero");
    property p_in; ws && reg_wdata_i[0] |-> ##2 !pin_oe_o; endproperty
    a_in: assert property (p_in) else $error("input pin driven");
    property p_pp; ws && reg_wdata_i[2:0] == 3'b100 |-> ##2 pin_oe_o && pin_o == $past(reg_wdata_i[3], 2); endproperty
    a_pp: assert property (p_pp) else $error("push-pull drive wrong");
    property p_od; ws && reg_wdata_i[2:0] == 3'b000 |-> ##2 pin_oe_o != $past(reg_wdata_i[3], 2) && !(pin_oe_o && pin_o); endproperty
    a_od: assert property (p_od) else $error("open-drain drive wrong");
    property p_alt; ws |-> ##2 alt_lowpower_o == $past(reg_wdata_i[5], 2); endproperty
    a_alt: assert property (p_alt) else $error("alternate output wrong");
    property p_rst; $rose(rst_n_i) |-> !pin_oe_o; endproperty
    a_rst: assert property (p_rst) else $error("pin driven after reset");
    property p_alt_rst; $rose(rst_n_i) |-> alt_lowpower_o == ALT_RESET; endproperty
    a_alt_rst: assert property (p_alt_rst) else $error("alternate reset value wrong");
    property p_rsvd; reg_rd_i && reg_addr_i == 8'h13 |=> reg_rdata_o[7:6] == 2'b00; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
endmodule // ptc_pin_two_monitor
bind ptc_pin_two ptc_pin_two_monitor #(
    .CHIP_CODE (CHIP_CODE),
    .ALT_RESET (ALT_RESET)
) mon_u (
    .sys_clk_i      (sys_clk_i),
    .rst_n_i        (rst_n_i),
    .reg_wr_i       (reg_wr_i),
    .reg_rd_i       (reg_rd_i),
    .pin_o          (pin_o),
    .pin_oe_o       (pin_oe_o),
    .alt_lowpower_o (alt_lowpower_o),
    .reg_addr_i     (reg_addr_i),
    .reg_wdata_i    (reg_wdata_i),
    .reg_rdata_o    (reg_rdata_o)
);

// ==== bench/ptc_pin_two_tb.sv ====
`timescale 1ns/1ps
module ptc_pin_two_tb;
    localparam [4:0] CODE = 5'h0_5;  // Arbitrary value
    localparam       ALT_DEF = 1'b1; // Factory alternate default under test
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, ext_en = 0, ext = 0, pad, po, poe, alt;
    logic [7:0] addr = 0, wd = 0, rdata, w;
    logic [31:0] s = 58627;
    int errors = 0, cmp_count = 0, cyc = 0;
    ptc_pin_two #(.DEBOUNCE_CYCLES(8), .CHIP_CODE(CODE), .ALT_RESET(ALT_DEF))
        dut_u (.sys_clk_i(clk), .rst_n_i(rst_n),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .pin_i(pad), .pin_o(po), .pin_oe_o(poe), .alt_lowpower_o(alt));
    ptc_pad_model pad_u (.oe_i(poe), .d_i(po), .ext_en_i(ext_en), .ext_i(ext), .pad_o(pad));
    initial forever #50 clk = ~clk;
    function logic [31:0] xs(input logic [31:0] x); x ^= x << 13; x ^= x >> 17; return x ^ (x << 5); endfunction
    function logic exp_oe(input logic [7:0] v); return !v[0] && (v[2] || !v[3]); endfunction
    task chk(input logic [7:0] g, e); cmp_count++;
        if (g !== e) begin errors++; $display("ERROR %0t got %h expected %h", $time, g, e); end
    endtask
    task wrt(input logic [7:0] a, d); @(posedge clk); #10 wr = 1; addr = a; wd = d; @(posedge clk); #10 wr = 0; endtask
    task rdc(input logic [7:0] a, e); @(posedge clk); #10 rd = 1; addr = a; @(posedge clk); #10 rd = 0; chk(rdata, e); endtask
    task tally_and_finish; $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin cyc++; if (cyc == 5000) begin errors++; tally_and_finish; end end
    initial begin
        repeat (3) @(posedge clk);
        #10 rst_n = 1;
        rdc(8'h14, {CODE[4], 3'b000, CODE[3:0]});
        rdc(8'h13, {2'b00, ALT_DEF, 5'h03});
        wrt(8'h14, 8'hFF);
        rdc(8'h14, {CODE[4], 3'b000, CODE[3:0]});
        rdc(8'h15, 8'h00);
        wrt(8'h13, 8'h08);
        repeat (3) @(posedge clk);
        chk({7'b0, poe}, 8'h00);
        repeat (40) begin
            s = xs(s); w = s[7:0] & 8'h2F; ext_en = s[8]; ext = s[9];
            wrt(8'h13, w);
            repeat (4) @(posedge clk);
            chk({6'b0, alt, poe}, {6'b0, w[5], exp_oe(w)});
            rdc(8'h13, {2'b00, w[5:2], exp_oe(w) ? w[3] : (ext_en ? ext : 1'b1), w[0]});
        end
        ext_en = 1; ext = 1;
        wrt(8'h13, 8'h11);
        repeat (16) @(posedge clk);
        #10 ext = 0;
        repeat (3) @(posedge clk);
        rdc(8'h13, 8'h13);
        repeat (10) @(posedge clk);
        rdc(8'h13, 8'h11);
        #10 rst_n = 0; @(posedge clk); #10 rst_n = 1;
        rdc(8'h13, {2'b00, ALT_DEF, 5'h01});
        tally_and_finish;
    end
endmodule // ptc_pin_two_tb

// ==== src/ptc_consts.vh ====
// Summary of operation
// - Direction bit 0 makes the pin an output, 1 an input; resets to input.
// - As output, drive-type bit 2 selects open-drain at 0, push-pull at 1.
// - Output-level bit 3 drives low at 0; high or released at 1 by drive type.
// - Read-only bit 1 reports the synchronised pin level, debounced while bit 4 is set.
// - Bit 5 selects the bias low-power alternate function; reset from the factory ALT_RESET option.
// - Code register bits 3:0 return identification code bits 3:0, read-only.
// - Code register bit 7 returns identification code bit 4, read-only.
// - The five-bit code is the CHIP_CODE identification value, independent of the ALT_RESET reset configuration.
// - Bit 4 enables a 30 ms debounce on the sampled input; resets to 0.
`ifndef PTC_CONSTS_VH
`define PTC_CONSTS_VH
`define PTC_ADDR_SETUP      8'h13
`define PTC_ADDR_CODE       8'h14
`define PTC_BIT_DIR         0
`define PTC_BIT_LEVEL       1
`define PTC_BIT_DRV         2
`define PTC_BIT_DOUT        3
`define PTC_BIT_DBEN        4
`define PTC_BIT_ALT         5
`define PTC_RST_DIR         1'b1
`define PTC_RST_DRV         1'b0
`define PTC_RST_DOUT        1'b0
`define PTC_RST_DBEN        1'b0
`define PTC_DEBOUNCE_MS     30
`define PTC_CLK_HZ          10000000
`define PTC_DEBOUNCE_CYC    ((`PTC_DEBOUNCE_MS * `PTC_CLK_HZ) / 1000)
`endif

// ==== src/ptc_debounce.v ====
`timescale 1ns/1ps
`include "ptc_consts.vh"
module ptc_debounce #(
    parameter integer CYCLES = `PTC_DEBOUNCE_CYC
) (
    input  wire sys_clk_i,  // System clock
    input  wire rst_n_i,    // Async reset, active low
    input  wire enable_i,   // Filter enable
    input  wire level_i,    // Synchronised raw level
    output reg  level_o     // Filtered level
);
    reg  [19:0] count_q;
    reg  [19:0] count_d;
    reg         level_d;

    always @* begin
        count_d = 20'h0_0000;
        level_d = level_o;
        if (!enable_i || level_i == level_o) begin
            if (!enable_i)
                level_d = level_i;
        end else if (count_q >= CYCLES[19:0] - 20'h0_0001) begin
            level_d = level_i;
        end else begin
            count_d = count_q + 20'h0_0001;
        end
    end

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_q <= 20'h0_0000;
            level_o <= 1'b0;
        end else begin
            count_q <= count_d;
            level_o <= level_d;
        end
    end
endmodule // ptc_debounce

// ==== src/ptc_pin_two.v ====
`timescale 1ns/1ps
`include "ptc_consts.vh"
module ptc_pin_two #(
    parameter integer     DEBOUNCE_CYCLES = `PTC_DEBOUNCE_CYC,
    parameter [4:0]       CHIP_CODE       = 5'h0_5,  // Arbitrary value
    parameter             ALT_RESET       = 1'b0     // Factory alternate-function default
) (
    input  wire       sys_clk_i,       // System clock, 10 MHz
    input  wire       rst_n_i,         // Async reset, active low
    input  wire [7:0] reg_addr_i,      // Register address
    input  wire       reg_wr_i,        // Write strobe, one cycle
    input  wire [7:0] reg_wdata_i,     // Write data
    input  wire       reg_rd_i,        // Read strobe, one cycle
    output reg  [7:0] reg_rdata_o,     // Read data, valid cycle after strobe
    input  wire       pin_i,           // Pin level from pad
    output reg        pin_o,           // Pin drive value
    output reg        pin_oe_o,        // Pin output enable, high while driving
    output reg        alt_lowpower_o   // Bias low-power alternate function active
);
    // Register map and read images
    localparam [7:0] ADDR_SETUP      = `PTC_ADDR_SETUP;
    localparam [7:0] ADDR_CODE       = `PTC_ADDR_CODE;
    localparam [1:0] RSVD_READ       = 2'b00;
    localparam [2:0] CODE_GAP        = 3'b000;
    localparam [7:0] RDATA_NONE      = 8'h00;

    // Pad drive modes decoded from direction and drive type
    localparam [1:0] MODE_INPUT      = 2'b00;
    localparam [1:0] MODE_OPEN_DRAIN = 2'b01;
    localparam [1:0] MODE_PUSH_PULL  = 2'b10;

    // Configuration fields and their next values
    reg        dir_q;
    reg        dir_d;
    reg        drv_q;
    reg        drv_d;
    reg        dout_q;
    reg        dout_d;
    reg        dben_q;
    reg        dben_d;
    reg        alt_d;
    reg        sync1_q;
    reg        sync2_q;
    reg        pin_d;
    reg        pin_oe_d;
    reg  [7:0] rdata_d;

    wire       level_filt;
    wire       setup_wr_hit;
    wire [1:0] mode;
    wire [7:0] setup_rd;
    wire [7:0] code_rd;

    // True when the address selects the pin setup register
    function is_setup;
        input [7:0] addr;
        begin
            is_setup = (addr == ADDR_SETUP);
        end
    endfunction

    function is_code;
        input [7:0] addr;
        begin
            is_code = (addr == ADDR_CODE);
        end
    endfunction

    // Direction wins over drive type
    function [1:0] pin_mode;
        input dir_in;
        input drv_push;
        begin
            if (dir_in)
                pin_mode = MODE_INPUT;
            else if (drv_push)
                pin_mode = MODE_PUSH_PULL;
            else
                pin_mode = MODE_OPEN_DRAIN;
        end
    endfunction

    // Open-drain only ever pulls low; a high level leaves the pad released
    function drive_on;
        input [1:0] mode_in;
        input       level;
        begin
            case (mode_in)
                MODE_PUSH_PULL:  drive_on = 1'b1;
                MODE_OPEN_DRAIN: drive_on = !level;
                default:         drive_on = 1'b0;
            endcase
        end
    endfunction

    // Readback image; reserved bits read zero
    function [7:0] setup_image;
        input alt;
        input dben;
        input dout;
        input drv;
        input lvl;
        input dir;
        begin
            setup_image = {RSVD_READ, alt, dben, dout, drv, lvl, dir};
        end
    endfunction

    // Identification code bit 4 on top, bits 3:0 at the bottom
    function [7:0] code_image;
        input [4:0] code;
        begin
            code_image = {code[4], CODE_GAP, code[3:0]};
        end
    endfunction

    // Unmapped addresses read as zero
    function [7:0] read_mux;
        input [7:0] addr;
        input [7:0] setup_val;
        input [7:0] code_val;
        begin
            if (is_setup(addr))
                read_mux = setup_val;
            else if (is_code(addr))
                read_mux = code_val;
            else
                read_mux = RDATA_NONE;
        end
    endfunction

    // Two-stage synchroniser for the asynchronous pad level
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
        end
    end

    ptc_debounce #(
        .CYCLES (DEBOUNCE_CYCLES)
    ) u_debounce (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .enable_i  (dben_q),
        .level_i   (sync2_q),
        .level_o   (level_filt)
    );

    assign setup_wr_hit = reg_wr_i && is_setup(reg_addr_i);
    assign mode         = pin_mode(dir_q, drv_q);
    assign setup_rd     = setup_image(alt_lowpower_o, dben_q, dout_q, drv_q, level_filt, dir_q);
    assign code_rd      = code_image(CHIP_CODE);

    // Next field values on a setup write; the code register ignores writes
    always @* begin
        dir_d  = dir_q;
        drv_d  = drv_q;
        dout_d = dout_q;
        dben_d = dben_q;
        alt_d  = alt_lowpower_o;
        if (setup_wr_hit) begin
            dir_d  = reg_wdata_i[`PTC_BIT_DIR];
            drv_d  = reg_wdata_i[`PTC_BIT_DRV];
            dout_d = reg_wdata_i[`PTC_BIT_DOUT];
            dben_d = reg_wdata_i[`PTC_BIT_DBEN];
            alt_d  = reg_wdata_i[`PTC_BIT_ALT];
        end
    end

    // Read data change only on a read strobe and then hold
    always @* begin
        rdata_d = reg_rdata_o;
        if (reg_rd_i)
            rdata_d = read_mux(reg_addr_i, setup_rd, code_rd);
    end

    // Pad drive decode
    always @* begin
        pin_d    = dout_q;
        pin_oe_d = drive_on(mode, dout_q);
    end

    // Setup fields; the alternate bit resets to the factory option
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dir_q          <= `PTC_RST_DIR;
            drv_q          <= `PTC_RST_DRV;
            dout_q         <= `PTC_RST_DOUT;
            dben_q         <= `PTC_RST_DBEN;
            alt_lowpower_o <= ALT_RESET;
        end else begin
            dir_q          <= dir_d;
            drv_q          <= drv_d;
            dout_q         <= dout_d;
            dben_q         <= dben_d;
            alt_lowpower_o <= alt_d;
        end
    end

    // Read data register holds until the next read
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            reg_rdata_o <= RDATA_NONE;
        else
            reg_rdata_o <= rdata_d;
    end

    // Pad drive leaves straight from flip-flops
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_o    <= 1'b0;
            pin_oe_o <= 1'b0;
        end else begin
            pin_o    <= pin_d;
            pin_oe_o <= pin_oe_d;
        end
    end
endmodule // ptc_pin_two
